// *** sim/mdsrd_spi_master.sv ***
// Serial bus master model for the register decode bench
`timescale 1ns/1ps
module mdsrd_spi_master
(
  input  wire logic mclk_i,
  input  wire logic sdo_i,
  output logic      sck_o,
  output logic      csn_o,
  output logic      sdi_o
);
  initial {sck_o, csn_o, sdi_o} = 3'h2;
  // One frame of n bits; the first 20 bits seen on sdo form rx
  task automatic xfer(input logic [31:0] w, input int n, output logic [19:0] rx);
    rx = 20'h00000;
    @(negedge mclk_i);
    csn_o = 1'b0;
    sdi_o = w[n-1];
    for (int k = 0; k < n; k++)
    begin
      repeat (4) @(negedge mclk_i);
      sck_o = 1'b1;
      if (k < 20) rx[19-k] = sdo_i;
      repeat (4) @(negedge mclk_i);
      sck_o = 1'b0;
      sdi_o = (k < n - 1) ? w[n-2-k] : ~sdi_o;
    end
    repeat (4) @(negedge mclk_i);
    csn_o = 1'b1;
    sdi_o = ~sdi_o;
    repeat (6) @(negedge mclk_i);
  endtask
endmodule

// *** sim/mdsrd_tb.sv ***
// Self-checking bench for the serial register decode
`timescale 1ns/1ps
module mdsrd_tb;
  logic        mclk_i, rst_n_i, en_i, sck_i, csn_i, sdi_i, sdo_o, sdo_oe_o;
  logic [9:0]  microstep_position_i, stall_load_value_i;
  logic [4:0]  actual_current_level_i;
  logic [7:0]  flg, coil_a_current_o, coil_b_current_o;
  logic [19:0] driver_control_o, chopper_config_o, load_current_config_o, rx;
  logic [19:0] stall_current_config_o, driver_config_o;
  logic        step_input_disable_o, step_dir_enable_o, coil_a_polarity_o;
  logic        coil_b_polarity_o, step_interpolation_o, double_edge_step_o;
  logic [1:0]  readback_select_o;
  logic [3:0]  microstep_resolution_o;
  logic [19:0] exp_r [5];
  int          fail_count, cmp_count, cyc;
  mdsrd_top dut
  (
    .mclk_i, .rst_n_i, .en_i, .sck_i, .csn_i, .sdi_i, .sdo_o, .sdo_oe_o,
    .microstep_position_i, .stall_load_value_i, .actual_current_level_i,
    .standstill_flag_i(flg[7]), .open_load_b_i(flg[6]), .open_load_a_i(flg[5]),
    .short_to_ground_b_i(flg[4]), .short_to_ground_a_i(flg[3]),
    .overtemp_warning_i(flg[2]), .overtemp_shutdown_i(flg[1]), .stall_detected_i(flg[0]),
    .driver_control_o, .chopper_config_o, .load_current_config_o, .stall_current_config_o,
    .driver_config_o, .step_input_disable_o, .step_dir_enable_o, .readback_select_o,
    .coil_a_polarity_o, .coil_a_current_o, .coil_b_polarity_o, .coil_b_current_o,
    .step_interpolation_o, .double_edge_step_o, .microstep_resolution_o
  );
  mdsrd_spi_master master (.mclk_i, .sdo_i(sdo_o), .sck_o(sck_i), .csn_o(csn_i), .sdi_o(sdi_i));
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out();
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Sends a frame, then compares all five stored registers
  task automatic wr(input logic [31:0] w, input int n);
    master.xfer(w, n, rx);
    if (n >= 20)
      case (w[19:17])
        3'h4: exp_r[1] = w[19:0] & 20'h1FFFF;
        3'h5: exp_r[2] = w[19:0] & 20'h0EF6F;
        3'h6: exp_r[3] = w[19:0] & 20'h17F1F;
        3'h7: exp_r[4] = w[19:0] & 20'h1F7F0;
        default: exp_r[0] = w[19:0] & 20'h3FFFF;
      endcase
    chk(driver_control_o, exp_r[0]);
    chk(chopper_config_o, exp_r[1]);
    chk(load_current_config_o, exp_r[2]);
    chk(stall_current_config_o, exp_r[3]);
    chk(driver_config_o, exp_r[4]);
  endtask
  task automatic t_regs();
    logic [19:0] t [5] = '{20'h0030F, 20'h9FFFF, 20'hAEF6F, 20'hD7F1F, 20'hFF7F0};
    foreach (t[i]) wr(t[i], 20);
  endtask
  task automatic t_mode();
    wr(20'hE0080, 20);
    wr(20'h2A5C3, 20);
    chk({2'h0, coil_a_polarity_o, coil_a_current_o, coil_b_polarity_o, coil_b_current_o}, 20'h2A5C3);
    chk({18'h0, step_input_disable_o, step_dir_enable_o}, 20'h2);
    wr(20'hE0000, 20);
    chk({14'h0, step_interpolation_o, double_edge_step_o, microstep_resolution_o}, 20'h13);
    chk({2'h0, coil_a_polarity_o, coil_a_current_o, coil_b_polarity_o, coil_b_current_o}, 20'h0);
  endtask
  task automatic t_read();
    logic [19:0] e;
    for (int s = 0; s < 4; s++)
    begin
      wr(32'hE0000 | (32'(s) << 4), 20);
      chk({18'h0, readback_select_o}, 20'(s));
      e = {microstep_position_i, 2'h0, flg};
      if (s == 1) e = {stall_load_value_i, 2'h0, flg};
      if (s == 2) e = {stall_load_value_i[9:5], actual_current_level_i, 2'h0, flg};
      wr(32'hE0000 | (32'(s) << 4), 20);
      chk(rx, e);
    end
  endtask
  // Output enable stands through the frame and drops after it
  task automatic t_oe();
    fork
      wr(32'hE0000, 20);
      begin
        repeat (20) @(negedge mclk_i);
        chk({19'h0, sdo_oe_o}, 20'h1);
      end
    join
    chk({19'h0, sdo_oe_o}, 20'h0);
  endtask
  // A frame sent while the clock enable is low must change nothing
  task automatic t_freeze();
    en_i = 1'b0;
    master.xfer(32'h00000, 20, rx);
    en_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    chk(driver_control_o, exp_r[0]);
    chk({19'h0, sdo_oe_o}, 20'h0);
  endtask
  initial
  begin
    {rst_n_i, en_i, microstep_position_i, stall_load_value_i} = {2'h1, 10'h2A5, 10'h1C3};
    {actual_current_level_i, flg} = {5'h16, 8'hA5};
    foreach (exp_r[i]) exp_r[i] = 20'h00000;
    repeat (4) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk({19'h0, step_dir_enable_o} | driver_config_o, 20'h1);
    t_regs();
    wr(32'h0008_5555, 19);
    wr(32'h00F8_0ABC, 24);
    t_mode();
    t_read();
    t_oe();
    t_freeze();
    close_out();
  end
endmodule

// *** verilog/mdsrd_pin_sync.sv ***
// Two-stage pin synchroniser with edge detection for the serial bus
`timescale 1ns/1ps
module mdsrd_pin_sync
(
  input  wire logic      mclk_i,
  input  wire logic      rst_n_i,
  input  wire logic      en_i,
  input  wire logic      sck_i,
  input  wire logic      csn_i,
  input  wire logic      sdi_i,
  mdsrd_ser_if.src       ser
);
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] s1_nxt;
  logic [2:0] s2_nxt;
  logic [2:0] s3_nxt;

  always_comb
  begin
    s1_nxt = {sck_i, csn_i, sdi_i};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_r <= mdsrd_pkg::PIN_IDLE;
      s2_r <= mdsrd_pkg::PIN_IDLE;
      s3_r <= mdsrd_pkg::PIN_IDLE;
    end
    else if (en_i)
    begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  // Edges come from the second and third stages only
  assign ser.sck_rise = en_i & s2_r[mdsrd_pkg::PIN_SCK] & ~s3_r[mdsrd_pkg::PIN_SCK];
  assign ser.sck_fall = en_i & ~s2_r[mdsrd_pkg::PIN_SCK] & s3_r[mdsrd_pkg::PIN_SCK];
  assign ser.cs_fall  = en_i & ~s2_r[mdsrd_pkg::PIN_CSN] & s3_r[mdsrd_pkg::PIN_CSN];
  assign ser.cs_rise  = en_i & s2_r[mdsrd_pkg::PIN_CSN] & ~s3_r[mdsrd_pkg::PIN_CSN];
  assign ser.cs_act   = ~s2_r[mdsrd_pkg::PIN_CSN];
  assign ser.sdi      = s2_r[mdsrd_pkg::PIN_SDI];
endmodule

// *** verilog/mdsrd_pkg.sv ***
// Constants, types and decode helpers for the motor driver serial register decode
// Operation
// - Every finished transaction of 20 or more clocks writes exactly one of five write-only registers.
// - Target comes from bits 19 and 18, bit 17 only where needed.
// - 00 drive control; 100 chopper; 101 load current; 110 stall; 111 drive config.
// - Step disable set: A polarity 17, A current 16:9, B polarity 8, B current 7:0.
// - Step disable clear: interpolation 9, double edge 8, resolution 3:0, rest zero.
// - Chopper fields: blank, mode, random, decrement, end, start, off time in 16:0.
// - Load fields: min half 15, down 14:13, upper 11:8, up 6:5, lower 3:0.
// - Stall fields: filter 16, threshold 14:8, scale 4:0; others zero.
// - Drive config: test, slopes, short protect, timer, step disable, sense, select.
// - Step disable gates step interface; select picks later response contents.
// - Two-bit select chooses among three response layouts.
// - Bits 19:10 hold position, load value, or load high plus current scale.
// - Bits 7:0 hold eight status flags high to low; bits 9:8 undefined.
// - Chip select rise latches the last 20 shifted bits as the command.
// - MSB first, sample on clock rise, change output after fall, 20 clocks minimum.
// - Step disable set ignores step inputs; clear makes drive control configure them.
package mdsrd_pkg;

  localparam int unsigned CMD_W    = 20;
  localparam int unsigned CUR_W    = 8;
  localparam int unsigned MSR_W    = 4;
  localparam int unsigned RBSEL_W  = 2;
  localparam int unsigned FIELD_W  = 10;
  localparam int unsigned SCALE_W  = 5;
  localparam int unsigned FLAG_W   = 8;
  localparam int unsigned CNT_W    = 5;
  localparam logic [CNT_W-1:0] MIN_CLKS = 5'h14;

  // Address field
  localparam int unsigned ADDR_HI  = 19;
  localparam int unsigned ADDR_LO  = 17;
  localparam int unsigned ADDR_MID = 18;
  localparam logic [1:0] ADDR_CTRL  = 2'h0;
  localparam logic [2:0] ADDR_CHOP  = 3'h4;
  localparam logic [2:0] ADDR_LOAD  = 3'h5;
  localparam logic [2:0] ADDR_STALL = 3'h6;
  localparam logic [2:0] ADDR_DRV   = 3'h7;

  // Bits that each register keeps
  localparam logic [CMD_W-1:0] MASK_CTRL  = 20'h3FFFF;
  localparam logic [CMD_W-1:0] MASK_CHOP  = 20'h1FFFF;
  localparam logic [CMD_W-1:0] MASK_LOAD  = 20'h0EF6F;
  localparam logic [CMD_W-1:0] MASK_STALL = 20'h17F1F;
  localparam logic [CMD_W-1:0] MASK_DRV   = 20'h1F7F0;
  localparam logic [CMD_W-1:0] RST_CFG    = 20'h00000;

  // Field positions
  localparam int unsigned APOL_BIT    = 17;
  localparam int unsigned ACUR_LSB    = 9;
  localparam int unsigned BPOL_BIT    = 8;
  localparam int unsigned BCUR_LSB    = 0;
  localparam int unsigned INTERP_BIT  = 9;
  localparam int unsigned DBLEDGE_BIT = 8;
  localparam int unsigned MSR_LSB     = 0;
  localparam int unsigned STOFF_BIT   = 7;
  localparam int unsigned RBSEL_LSB   = 4;
  localparam int unsigned RSP_HI_LSB = 10;

  // Pin vector {sck, csn, sdi} and its idle value
  localparam int unsigned PIN_SCK  = 2;
  localparam int unsigned PIN_CSN  = 1;
  localparam int unsigned PIN_SDI  = 0;
  localparam logic [2:0]  PIN_IDLE = 3'h2;

  typedef enum logic [1:0] {
    RD_POS  = 2'b00,
    RD_LOAD = 2'b01,
    RD_MIX  = 2'b10,
    RD_RSVD = 2'b11
  } mdsrd_rbsel_e;

  typedef enum logic [2:0] {
    TGT_NONE  = 3'b000,
    TGT_CTRL  = 3'b001,
    TGT_CHOP  = 3'b010,
    TGT_LOAD  = 3'b011,
    TGT_STALL = 3'b100,
    TGT_DRV   = 3'b101
  } mdsrd_tgt_e;

  function automatic mdsrd_tgt_e mdsrd_decode(input logic [CMD_W-1:0] cmd);
    mdsrd_tgt_e t;
    t = TGT_CTRL;
    if (cmd[ADDR_HI:ADDR_MID] != ADDR_CTRL)
    begin
      case (cmd[ADDR_HI:ADDR_LO])
        ADDR_CHOP:  t = TGT_CHOP;
        ADDR_LOAD:  t = TGT_LOAD;
        ADDR_STALL: t = TGT_STALL;
        ADDR_DRV:   t = TGT_DRV;
        default:    t = TGT_CTRL;
      endcase
    end
    return t;
  endfunction

  function automatic logic [CMD_W-1:0] mdsrd_resp(input logic [RBSEL_W-1:0] sel,
                                                  input logic [FIELD_W-1:0] pos,
                                                  input logic [FIELD_W-1:0] load,
                                                  input logic [SCALE_W-1:0] scale,
                                                  input logic [FLAG_W-1:0]  flags);
    logic [FIELD_W-1:0] hi;
    hi = pos;
    case (sel)
      RD_LOAD: hi = load;
      RD_MIX:  hi = {load[FIELD_W-1:SCALE_W], scale};
      default: hi = pos;
    endcase
    return {hi, 2'h0, flags};
  endfunction

endpackage

// *** verilog/mdsrd_ser_if.sv ***
// Synchronised serial pin events passed from the pin stage to the shifter
`timescale 1ns/1ps
interface mdsrd_ser_if;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic cs_act;
  logic sdi;
  modport src (output sck_rise, output sck_fall, output cs_fall, output cs_rise,
               output cs_act, output sdi);
  modport dst (input sck_rise, input sck_fall, input cs_fall, input cs_rise,
               input cs_act, input sdi);
endinterface

// *** verilog/mdsrd_shifter.sv ***
// Serial shift register: response load, command capture and data out
`timescale 1ns/1ps
module mdsrd_shifter
(
  input  wire logic                        mclk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        en_i,
  mdsrd_ser_if.dst                         ser,
  input  wire logic [mdsrd_pkg::CMD_W-1:0] resp_i,
  output logic      [mdsrd_pkg::CMD_W-1:0] cmd_o,
  output logic                             cmd_valid_o,
  output logic                             sdo_o
);
  logic [mdsrd_pkg::CMD_W-1:0] sh_r;
  logic [mdsrd_pkg::CMD_W-1:0] sh_nxt;
  logic [mdsrd_pkg::CMD_W-1:0] cmd_r;
  logic [mdsrd_pkg::CMD_W-1:0] cmd_nxt;
  logic [mdsrd_pkg::CNT_W-1:0] cnt_r;
  logic [mdsrd_pkg::CNT_W-1:0] cnt_nxt;
  logic                        sdo_r;
  logic                        sdo_nxt;
  logic                        vld_r;
  logic                        vld_nxt;

  always_comb
  begin
    sh_nxt  = sh_r;
    sdo_nxt = sdo_r;
    cmd_nxt = cmd_r;
    cnt_nxt = cnt_r;
    vld_nxt = 1'b0;
    if (ser.cs_fall)
    begin
      sh_nxt  = resp_i;
      sdo_nxt = resp_i[mdsrd_pkg::CMD_W-1];
      cnt_nxt = '0;
    end
    else if (ser.cs_act && ser.sck_rise)
    begin
      sh_nxt = {sh_r[mdsrd_pkg::CMD_W-2:0], ser.sdi};
      if (cnt_r != mdsrd_pkg::MIN_CLKS)
      begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
    else if (ser.cs_act && ser.sck_fall)
    begin
      sdo_nxt = sh_r[mdsrd_pkg::CMD_W-1];
    end
    // Short transfers are dropped
    if (ser.cs_rise && (cnt_r == mdsrd_pkg::MIN_CLKS))
    begin
      cmd_nxt = sh_r;
      vld_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sh_r  <= mdsrd_pkg::RST_CFG;
      cmd_r <= mdsrd_pkg::RST_CFG;
      cnt_r <= '0;
      sdo_r <= 1'b0;
      vld_r <= 1'b0;
    end
    else if (en_i)
    begin
      sh_r  <= sh_nxt;
      cmd_r <= cmd_nxt;
      cnt_r <= cnt_nxt;
      sdo_r <= sdo_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign cmd_o       = cmd_r;
  assign cmd_valid_o = vld_r;
  assign sdo_o       = sdo_r;

  default clocking sh_cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  resp_capture_a: assert property (
    ser.cs_fall |=> (sh_r == $past(resp_i)) && (sdo_o == $past(resp_i[19])))
    else $error("response word not captured at chip select fall");

  cmd_latch_a: assert property (
    ser.cs_rise && (cnt_r == mdsrd_pkg::MIN_CLKS) |=> cmd_valid_o && (cmd_o == $past(sh_r)))
    else $error("command not latched at chip select rise");
endmodule

// *** verilog/mdsrd_top.sv ***
// Serial command decode into five write-only driver registers and status readback
`timescale 1ns/1ps
module mdsrd_top
(
  input  wire logic                          mclk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          en_i,
  input  wire logic                          sck_i,
  input  wire logic                          csn_i,
  input  wire logic                          sdi_i,
  output logic                               sdo_o,
  output logic                               sdo_oe_o,
  input  wire logic [mdsrd_pkg::FIELD_W-1:0] microstep_position_i,
  input  wire logic [mdsrd_pkg::FIELD_W-1:0] stall_load_value_i,
  input  wire logic [mdsrd_pkg::SCALE_W-1:0] actual_current_level_i,
  input  wire logic                          standstill_flag_i,
  input  wire logic                          open_load_b_i,
  input  wire logic                          open_load_a_i,
  input  wire logic                          short_to_ground_b_i,
  input  wire logic                          short_to_ground_a_i,
  input  wire logic                          overtemp_warning_i,
  input  wire logic                          overtemp_shutdown_i,
  input  wire logic                          stall_detected_i,
  output logic      [mdsrd_pkg::CMD_W-1:0]   driver_control_o,
  output logic      [mdsrd_pkg::CMD_W-1:0]   chopper_config_o,
  output logic      [mdsrd_pkg::CMD_W-1:0]   load_current_config_o,
  output logic      [mdsrd_pkg::CMD_W-1:0]   stall_current_config_o,
  output logic      [mdsrd_pkg::CMD_W-1:0]   driver_config_o,
  output logic                               step_input_disable_o,
  output logic                               step_dir_enable_o,
  output logic      [mdsrd_pkg::RBSEL_W-1:0] readback_select_o,
  output logic                               coil_a_polarity_o,
  output logic      [mdsrd_pkg::CUR_W-1:0]   coil_a_current_o,
  output logic                               coil_b_polarity_o,
  output logic      [mdsrd_pkg::CUR_W-1:0]   coil_b_current_o,
  output logic                               step_interpolation_o,
  output logic                               double_edge_step_o,
  output logic      [mdsrd_pkg::MSR_W-1:0]   microstep_resolution_o
);

  // ----------------------------------------------------------------
  // Serial front end
  // ----------------------------------------------------------------
  logic [mdsrd_pkg::CMD_W-1:0]  cmd_w;
  logic                         cmd_vld;
  logic [mdsrd_pkg::CMD_W-1:0]  resp_w;
  logic [mdsrd_pkg::FLAG_W-1:0] flags_w;
  logic [mdsrd_pkg::CMD_W-1:0]  drv_r;

  mdsrd_ser_if ser_bus ();

  mdsrd_pin_sync u_sync
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .en_i    (en_i),
    .sck_i   (sck_i),
    .csn_i   (csn_i),
    .sdi_i   (sdi_i),
    .ser     (ser_bus.src)
  );

  mdsrd_shifter u_shift
  (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .en_i        (en_i),
    .ser         (ser_bus.dst),
    .resp_i      (resp_w),
    .cmd_o       (cmd_w),
    .cmd_valid_o (cmd_vld),
    .sdo_o       (sdo_o)
  );

  assign sdo_oe_o = ser_bus.cs_act;

  // ----------------------------------------------------------------
  // Response word
  // ----------------------------------------------------------------
  assign flags_w = {standstill_flag_i,
                    open_load_b_i,
                    open_load_a_i,
                    short_to_ground_b_i,
                    short_to_ground_a_i,
                    overtemp_warning_i,
                    overtemp_shutdown_i,
                    stall_detected_i};

  // Layout follows the select field of the stored drive config
  assign resp_w = mdsrd_pkg::mdsrd_resp(
                    drv_r[mdsrd_pkg::RBSEL_LSB +: mdsrd_pkg::RBSEL_W],
                    microstep_position_i,
                    stall_load_value_i,
                    actual_current_level_i,
                    flags_w);

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [mdsrd_pkg::CMD_W-1:0] ctrl_r;
  logic [mdsrd_pkg::CMD_W-1:0] chop_r;
  logic [mdsrd_pkg::CMD_W-1:0] load_r;
  logic [mdsrd_pkg::CMD_W-1:0] stall_r;
  logic [mdsrd_pkg::CMD_W-1:0] ctrl_nxt;
  logic [mdsrd_pkg::CMD_W-1:0] chop_nxt;
  logic [mdsrd_pkg::CMD_W-1:0] load_nxt;
  logic [mdsrd_pkg::CMD_W-1:0] stall_nxt;
  logic [mdsrd_pkg::CMD_W-1:0] drv_nxt;
  mdsrd_pkg::mdsrd_tgt_e       tgt;

  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    chop_nxt  = chop_r;
    load_nxt  = load_r;
    stall_nxt = stall_r;
    drv_nxt   = drv_r;
    tgt       = mdsrd_pkg::TGT_NONE;
    if (cmd_vld)
    begin
      tgt = mdsrd_pkg::mdsrd_decode(cmd_w);
    end
    // Exactly one register takes each command
    case (tgt)
      mdsrd_pkg::TGT_CTRL:  ctrl_nxt  = cmd_w & mdsrd_pkg::MASK_CTRL;
      mdsrd_pkg::TGT_CHOP:  chop_nxt  = cmd_w & mdsrd_pkg::MASK_CHOP;
      mdsrd_pkg::TGT_LOAD:  load_nxt  = cmd_w & mdsrd_pkg::MASK_LOAD;
      mdsrd_pkg::TGT_STALL: stall_nxt = cmd_w & mdsrd_pkg::MASK_STALL;
      mdsrd_pkg::TGT_DRV:   drv_nxt   = cmd_w & mdsrd_pkg::MASK_DRV;
      default:              ctrl_nxt  = ctrl_r;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r  <= mdsrd_pkg::RST_CFG;
      chop_r  <= mdsrd_pkg::RST_CFG;
      load_r  <= mdsrd_pkg::RST_CFG;
      stall_r <= mdsrd_pkg::RST_CFG;
      drv_r   <= mdsrd_pkg::RST_CFG;
    end
    else if (en_i)
    begin
      ctrl_r  <= ctrl_nxt;
      chop_r  <= chop_nxt;
      load_r  <= load_nxt;
      stall_r <= stall_nxt;
      drv_r   <= drv_nxt;
    end
  end

  assign driver_control_o       = ctrl_r;
  assign chopper_config_o       = chop_r;
  assign load_current_config_o  = load_r;
  assign stall_current_config_o = stall_r;
  assign driver_config_o        = drv_r;

  // ----------------------------------------------------------------
  // Mode-dependent field outputs
  // ----------------------------------------------------------------
  logic                              stoff_r;
  logic                              stoff_nxt;
  logic                              sden_r;
  logic                              sden_nxt;
  logic [mdsrd_pkg::RBSEL_W-1:0]     rbsel_r;
  logic [mdsrd_pkg::RBSEL_W-1:0]     rbsel_nxt;
  logic                              apol_r;
  logic                              apol_nxt;
  logic [mdsrd_pkg::CUR_W-1:0]       acur_r;
  logic [mdsrd_pkg::CUR_W-1:0]       acur_nxt;
  logic                              bpol_r;
  logic                              bpol_nxt;
  logic [mdsrd_pkg::CUR_W-1:0]       bcur_r;
  logic [mdsrd_pkg::CUR_W-1:0]       bcur_nxt;
  logic                              intp_r;
  logic                              intp_nxt;
  logic                              dbl_r;
  logic                              dbl_nxt;
  logic [mdsrd_pkg::MSR_W-1:0]       msr_r;
  logic [mdsrd_pkg::MSR_W-1:0]       msr_nxt;

  always_comb
  begin
    stoff_nxt = drv_r[mdsrd_pkg::STOFF_BIT];
    sden_nxt  = ~drv_r[mdsrd_pkg::STOFF_BIT];
    rbsel_nxt = drv_r[mdsrd_pkg::RBSEL_LSB +: mdsrd_pkg::RBSEL_W];
    apol_nxt  = 1'b0;
    acur_nxt  = '0;
    bpol_nxt  = 1'b0;
    bcur_nxt  = '0;
    intp_nxt  = 1'b0;
    dbl_nxt   = 1'b0;
    msr_nxt   = '0;
    if (drv_r[mdsrd_pkg::STOFF_BIT])
    begin
      // Coils set directly, step inputs ignored
      apol_nxt = ctrl_r[mdsrd_pkg::APOL_BIT];
      acur_nxt = ctrl_r[mdsrd_pkg::ACUR_LSB +: mdsrd_pkg::CUR_W];
      bpol_nxt = ctrl_r[mdsrd_pkg::BPOL_BIT];
      bcur_nxt = ctrl_r[mdsrd_pkg::BCUR_LSB +: mdsrd_pkg::CUR_W];
    end
    else
    begin
      intp_nxt  = ctrl_r[mdsrd_pkg::INTERP_BIT];
      dbl_nxt   = ctrl_r[mdsrd_pkg::DBLEDGE_BIT];
      msr_nxt   = ctrl_r[mdsrd_pkg::MSR_LSB +: mdsrd_pkg::MSR_W];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stoff_r <= 1'b0;
      sden_r  <= 1'b1;
      rbsel_r <= '0;
      apol_r  <= 1'b0;
      acur_r  <= '0;
      bpol_r  <= 1'b0;
      bcur_r  <= '0;
      intp_r  <= 1'b0;
      dbl_r   <= 1'b0;
      msr_r   <= '0;
    end
    else if (en_i)
    begin
      stoff_r <= stoff_nxt;
      sden_r  <= sden_nxt;
      rbsel_r <= rbsel_nxt;
      apol_r  <= apol_nxt;
      acur_r  <= acur_nxt;
      bpol_r  <= bpol_nxt;
      bcur_r  <= bcur_nxt;
      intp_r  <= intp_nxt;
      dbl_r   <= dbl_nxt;
      msr_r   <= msr_nxt;
    end
  end

  assign step_input_disable_o   = stoff_r;
  assign step_dir_enable_o      = sden_r;
  assign readback_select_o      = rbsel_r;
  assign coil_a_polarity_o      = apol_r;
  assign coil_a_current_o       = acur_r;
  assign coil_b_polarity_o      = bpol_r;
  assign coil_b_current_o       = bcur_r;
  assign step_interpolation_o   = intp_r;
  assign double_edge_step_o     = dbl_r;
  assign microstep_resolution_o = msr_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking top_cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  ctrl_write_a: assert property (
    en_i && cmd_vld && (cmd_w[19:18] == 2'h0)
    |=> driver_control_o == ($past(cmd_w) & mdsrd_pkg::MASK_CTRL))
    else $error("drive control not written for address 00");

  chop_write_a: assert property (
    en_i && cmd_vld && (cmd_w[19:17] == 3'h4)
    |=> chopper_config_o == ($past(cmd_w) & mdsrd_pkg::MASK_CHOP))
    else $error("chopper config not written for address 100");

  one_target_a: assert property (
    en_i && cmd_vld |=> $onehot0({ctrl_r != $past(ctrl_r), chop_r != $past(chop_r),
                                  load_r != $past(load_r), stall_r != $past(stall_r),
                                  drv_r != $past(drv_r)}))
    else $error("one command changed more than one register");

  hold_regs_a: assert property (
    !(en_i && cmd_vld) |=> $stable(ctrl_r) && $stable(chop_r) && $stable(load_r)
                           && $stable(stall_r) && $stable(drv_r))
    else $error("register changed without a command");

  rsvd_zero_a: assert property (
    ((load_r & ~mdsrd_pkg::MASK_LOAD) | (stall_r & ~mdsrd_pkg::MASK_STALL)
     | (drv_r & ~mdsrd_pkg::MASK_DRV)) == 20'h00000)
    else $error("reserved register bit is set");

  coil_direct_a: assert property (
    en_i && drv_r[7] |=> !step_dir_enable_o && (coil_a_current_o == $past(ctrl_r[16:9]))
                         && (coil_b_polarity_o == $past(ctrl_r[8])))
    else $error("coil fields wrong with step input disabled");

  step_cfg_a: assert property (
    en_i && !drv_r[7] |=> step_dir_enable_o && (coil_a_current_o == 8'h00)
                          && (microstep_resolution_o == $past(ctrl_r[3:0]))
                          && (step_interpolation_o == $past(ctrl_r[9])))
    else $error("step interface fields wrong with step input enabled");

  resp_flags_a: assert property (
    resp_w[9:0] == {2'h0, flags_w})
    else $error("status flags misplaced in response");

  resp_mix_a: assert property (
    drv_r[5:4] == 2'h2 |-> (resp_w[19:15] == stall_load_value_i[9:5])
                           && (resp_w[14:10] == actual_current_level_i))
    else $error("mixed response layout wrong");

  resp_rsvd_a: assert property (
    drv_r[5:4] == 2'h3 |-> resp_w[19:10] == microstep_position_i)
    else $error("reserved select did not give position layout");

  sel_follow_a: assert property (
    en_i |=> readback_select_o == $past(drv_r[5:4]))
    else $error("readback select output does not follow register");

  spi_mode_c:  cover property (en_i && cmd_vld && (cmd_w[19:17] == 3'h7) && cmd_w[7]);
  chop_cmd_c:  cover property (en_i && cmd_vld && (cmd_w[19:17] == 3'h4));
  mix_sel_c:   cover property (ser_bus.cs_fall && (drv_r[5:4] == 2'h2));
  rsvd_sel_c:  cover property (ser_bus.cs_fall && (drv_r[5:4] == 2'h3));

endmodule
